/* File: src/csb_pkg.sv */
// Behaviour
// - Hold one full block of channel status for A and B channels, 384 bits.
// - Handle channel status per whole block, re-timed to the output frame timebase.
// - Outside hardware pin mode the staging buffer hands whole blocks to the transmit buffer, which alone feeds output.
// - Send each stored byte most significant bit first.
// - First channel status byte sits at address 20h; its top bit is pro flag.
// - Host reads the staging buffer through the register space, and overwrites it outside hardware mode.
// - Raise an interrupt on every handoff while the interrupt enable is set.
// - Suppress every handoff while the inhibit bit is set.
// - Professional blocks get the CRC byte computed and sent in the last byte.
// - Hardware mode serial channel status input also gets the automatic CRC byte.
// - Hardware mode takes copy management from copy and original pins or serial pin.
// - Staging buffer is 24 words of 16 bits: A byte high, B byte low.
// - A control bit selects single-byte or paired-byte host access.
// - Single-byte read returns one byte, A or B half chosen by a control bit.
// - Single-byte write stores the byte in both halves of the addressed word.
// - Paired-byte read gives the A byte first, then the B byte.
package csb_pkg;
	localparam int          WORDS         = 24;
	localparam logic [7:0]  LAST_BIT      = 8'hBF;
	localparam logic [7:0]  CRC_START     = 8'hB8;
	localparam logic [4:0]  LAST_WORD     = 5'h17;
	localparam logic [7:0]  CTRL_ADDR     = 8'h10;
	localparam logic [7:0]  STAT_ADDR     = 8'h11;
	localparam logic [7:0]  BUF_BASE      = 8'h20;
	localparam logic [7:0]  BUF_LAST      = 8'h37;
	localparam logic [7:0]  STREAM_ADDR   = 8'h3F;
	localparam int          CTRL_TWO_BYTE = 0;
	localparam int          CTRL_RD_B     = 1;
	localparam int          CTRL_INHIBIT  = 2;
	localparam int          CTRL_IRQ_EN   = 3;
	localparam logic [3:0]  CTRL_RESET    = 4'h0;
	localparam int          STAT_HANDOFF  = 0;
	localparam int          STAT_HW       = 1;
	localparam logic [7:0]  CRC_INIT      = 8'hFF;
	localparam logic [7:0]  CRC_POLY      = 8'h1D;
	localparam int          PRO_BIT_A     = 15;
	localparam int          PRO_BIT_B     = 7;
	localparam int          COPY_BIT      = 5;
	localparam int          ORIGINAL_STATUS_PIN_BIT      = 0;
	localparam logic [4:0]  ORIGINAL_STATUS_PIN_WORD     = 5'h01;
	localparam int          PIN_HW        = 0;
	localparam int          PIN_SER_SEL   = 1;
	localparam int          PIN_SER_DATA  = 2;
	localparam int          PIN_COPY      = 3;
	localparam int          PIN_ORIGINAL_STATUS_PIN      = 4;
	localparam int          PIN_COUNT     = 5;
endpackage

/* File: src/crc_if.sv */
`timescale 1ns/1ps
interface crc_if;
	logic       clear;
	logic       step;
	logic       data_bit;
	logic [7:0] crc;
	modport ctl (output clear, output step, output data_bit, input crc);
	modport unit (input clear, input step, input data_bit, output crc);
endinterface

/* File: src/crc_unit.sv */
`timescale 1ns/1ps
module crc_unit
	import csb_pkg::*;
(
	input  wire logic clk_in,
	input  wire logic arst_n_in,
	crc_if.unit       port
);
	typedef struct packed {
		logic [7:0] crc;
	} crc_state_s;

	crc_state_s r;
	crc_state_s n;
	logic       fb;

	// ************************************************
	// Bitwise CRC, fed in transmission order
	// ************************************************
	always_comb begin
		n = r;
		fb = r.crc[7] ^ port.data_bit;
		if (port.clear) begin
			n.crc = CRC_INIT;
		end else if (port.step) begin
			n.crc = {r.crc[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
		end
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			r <= '{crc: CRC_INIT};
		end else begin
			r <= n;
		end
	end

	assign port.crc = r.crc;
endmodule

/* File: src/cs_buffer_manager.sv */
// The strobed register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module cs_buffer_manager
	import csb_pkg::*;
(
	input  wire logic       clk_in,
	input  wire logic       arst_n_in,
	input  wire logic [7:0] reg_addr_in,
	input  wire logic [7:0] reg_wdata_in,
	input  wire logic       reg_wr_in,
	input  wire logic       reg_rd_in,
	output logic      [7:0] reg_rdata_out,
	input  wire logic       frame_clk_in,
	input  wire logic       hw_mode_in,
	input  wire logic       hw_serial_sel_in,
	input  wire logic       cs_serial_in,
	input  wire logic       copy_permit_pin_in,
	input  wire logic       original_status_pin_in,
	output logic            cs_a_out,
	output logic            cs_b_out,
	output logic            block_start_out,
	output logic            handoff_irq_out
);
	import csb_pkg::*;

	typedef struct packed {
		logic [PIN_COUNT-1:0]  pin1;
		logic [PIN_COUNT-1:0]  pin2;
		logic                  fr1;
		logic                  fr2;
		logic                  fr3;
		logic [3:0]            ctrl;
		logic                  flag;
		logic                  irq;
		logic [7:0]            rdata;
		logic [4:0]            ptr;
		logic                  half;
		logic [7:0]            cnt;
		logic                  csa;
		logic                  csb;
		logic                  bstart;
		logic [WORDS-1:0][15:0] e;
		logic [WORDS-1:0][15:0] f;
	} state_s;

	state_s     r;
	state_s     n;
	logic       tick;
	logic       last;
	logic       hw;
	logic       in_window;
	logic [4:0] acc_idx;
	logic       acc_half;
	logic [4:0] next_idx;
	logic       two_byte;
	logic       inhibit;
	logic       tx_a;
	logic       tx_b;
	logic       crc_bit_a;
	logic       crc_bit_b;
	logic       crc_clr;
	logic       crc_step;
	logic [WORDS-1:0][15:0] pin_block;

	crc_if cif [2] ();

	// ************************************************
	// One CRC unit per channel
	// ************************************************
	generate
		for (genvar ch = 0; ch < 2; ch++) begin : g_crc
			crc_unit u_crc (
				.clk_in    (clk_in),
				.arst_n_in (arst_n_in),
				.port      (cif[ch].unit)
			);
			assign cif[ch].clear    = crc_clr;
			assign cif[ch].step     = crc_step;
			assign cif[ch].data_bit = (ch == 0) ? tx_a : tx_b;
		end
	endgenerate

	// ************************************************
	// Next-state logic
	// ************************************************
	always_comb begin
		n = r;
		n.pin1 = {original_status_pin_in, copy_permit_pin_in, cs_serial_in,
			hw_serial_sel_in, hw_mode_in};
		n.pin2 = r.pin1;
		n.fr1 = frame_clk_in;
		n.fr2 = r.fr1;
		n.fr3 = r.fr2;
		n.irq = 1'b0;
		n.bstart = 1'b0;
		n.rdata = 8'h00;

		// Rising frame clock edges pace the whole block machine
		tick = r.fr2 & ~r.fr3;
		last = (r.cnt == LAST_BIT);
		hw = r.pin2[PIN_HW];
		two_byte = r.ctrl[CTRL_TWO_BYTE];
		inhibit = r.ctrl[CTRL_INHIBIT];

		// Window address restarts an access, stream address continues it
		in_window = (reg_addr_in >= BUF_BASE) && (reg_addr_in <= BUF_LAST);
		acc_idx = in_window ? 5'(reg_addr_in - BUF_BASE) : r.ptr;
		acc_half = in_window ? 1'b0 : r.half;
		next_idx = (acc_idx >= LAST_WORD) ? 5'h00 : 5'(acc_idx + 5'h01);

		if (reg_wr_in) begin
			if (reg_addr_in == CTRL_ADDR) begin
				n.ctrl = reg_wdata_in[3:0];
			end else if ((in_window || reg_addr_in == STREAM_ADDR) && !hw) begin
				if (two_byte && !acc_half) begin
					n.e[acc_idx][15:8] = reg_wdata_in;
					n.ptr = acc_idx;
					n.half = 1'b1;
				end else if (two_byte) begin
					n.e[acc_idx][7:0] = reg_wdata_in;
					n.ptr = next_idx;
					n.half = 1'b0;
				end else begin
					n.e[acc_idx] = {reg_wdata_in, reg_wdata_in};
					n.ptr = next_idx;
					n.half = 1'b0;
				end
			end
		end

		if (reg_rd_in) begin
			if (reg_addr_in == CTRL_ADDR) begin
				n.rdata = {4'h0, r.ctrl};
			end else if (reg_addr_in == STAT_ADDR) begin
				n.rdata = {6'h00, hw, r.flag};
				n.flag = 1'b0;
			end else if (in_window || reg_addr_in == STREAM_ADDR) begin
				if (two_byte && !acc_half) begin
					n.rdata = r.e[acc_idx][15:8];
					n.ptr = acc_idx;
					n.half = 1'b1;
				end else if (two_byte) begin
					n.rdata = r.e[acc_idx][7:0];
					n.ptr = next_idx;
					n.half = 1'b0;
				end else begin
					n.rdata = r.ctrl[CTRL_RD_B] ? r.e[acc_idx][7:0] : r.e[acc_idx][15:8];
					n.ptr = next_idx;
					n.half = 1'b0;
				end
			end
		end

		// Transmit bits come from the transmit buffer only, MSB of each byte first
		tx_a = r.f[r.cnt[7:3]][8 + 7 - r.cnt[2:0]];
		tx_b = r.f[r.cnt[7:3]][7 - r.cnt[2:0]];
		crc_bit_a = cif[0].crc[~r.cnt[2:0]];
		crc_bit_b = cif[1].crc[~r.cnt[2:0]];
		crc_step = tick && (r.cnt < CRC_START);
		crc_clr = tick && last;

		// Hardware pin mode: copy permit and original flag build the block
		pin_block = '0;
		pin_block[0][8 + COPY_BIT] = r.pin2[PIN_COPY];
		pin_block[0][COPY_BIT] = r.pin2[PIN_COPY];
		pin_block[ORIGINAL_STATUS_PIN_WORD][8 + ORIGINAL_STATUS_PIN_BIT] = r.pin2[PIN_ORIGINAL_STATUS_PIN];
		pin_block[ORIGINAL_STATUS_PIN_WORD][ORIGINAL_STATUS_PIN_BIT] = r.pin2[PIN_ORIGINAL_STATUS_PIN];

		if (tick) begin
			if (hw && r.pin2[PIN_SER_SEL]) begin
				// Serial pin fills the staging buffer one bit per frame
				n.e[r.cnt[7:3]][8 + 7 - r.cnt[2:0]] = r.pin2[PIN_SER_DATA];
				n.e[r.cnt[7:3]][7 - r.cnt[2:0]] = r.pin2[PIN_SER_DATA];
			end
			// Professional blocks replace the last byte with the running CRC
			if (r.cnt >= CRC_START && r.f[0][PRO_BIT_A]) begin
				n.csa = crc_bit_a;
			end else begin
				n.csa = tx_a;
			end
			if (r.cnt >= CRC_START && r.f[0][PRO_BIT_B]) begin
				n.csb = crc_bit_b;
			end else begin
				n.csb = tx_b;
			end
			n.bstart = (r.cnt == 8'h00);
			if (last) begin
				n.cnt = 8'h00;
				if (!inhibit) begin
					// Whole block moves in one edge, before bit 0 of the next
					n.f = (hw && !r.pin2[PIN_SER_SEL]) ? pin_block : n.e;
					n.flag = 1'b1;
					n.irq = r.ctrl[CTRL_IRQ_EN];
				end
			end else begin
				n.cnt = 8'(r.cnt + 8'h01);
			end
		end
	end

	// ************************************************
	// State register
	// ************************************************
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign reg_rdata_out = r.rdata;
	assign cs_a_out = r.csa;
	assign cs_b_out = r.csb;
	assign block_start_out = r.bstart;
	assign handoff_irq_out = r.irq;

	// ************************************************
	// Assertions
	// ************************************************
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!arst_n_in);

	inhibit_holds_a: assert property (tick && last && inhibit |=> $stable(r.f))
		else $error("transmit buffer changed while inhibited");
	handoff_copy_a: assert property (tick && last && !inhibit && !hw |=> r.f == $past(n.e))
		else $error("handoff did not copy the staging buffer");
	irq_cause_a: assert property (handoff_irq_out |-> $past(tick && last && !inhibit
		&& r.ctrl[CTRL_IRQ_EN]))
		else $error("interrupt without an enabled handoff");
	irq_given_a: assert property (tick && last && !inhibit && r.ctrl[CTRL_IRQ_EN]
		|=> handoff_irq_out ##1 !handoff_irq_out)
		else $error("handoff interrupt missing or too long");
	single_write_a: assert property (reg_wr_in && in_window && !two_byte && !hw
		&& !tick |=> r.e[$past(acc_idx)] == {2{$past(reg_wdata_in)}})
		else $error("single byte write not copied to both halves");
	pair_order_a: assert property (reg_rd_in && in_window && two_byte ##1
		reg_rd_in && reg_addr_in == STREAM_ADDR && !tick && !$past(tick)
		|=> reg_rdata_out == r.e[$past(acc_idx)][7:0])
		else $error("second paired read was not the B byte");
	msb_first_a: assert property (tick && r.cnt < CRC_START |=> cs_a_out == $past(tx_a))
		else $error("A channel bit out of order");
	crc_slot_a: assert property (tick && r.cnt >= CRC_START && r.f[0][PRO_BIT_A]
		|=> cs_a_out == $past(crc_bit_a))
		else $error("CRC bit not sent in last byte");
	block_wrap_a: assert property (tick && last |=> r.cnt == 8'h00 ##0 !block_start_out)
		else $error("bit counter did not wrap at block end");
	ctrl_read_a: assert property (reg_rd_in && reg_addr_in == CTRL_ADDR
		|=> reg_rdata_out == {4'h0, $past(r.ctrl)} ##1 reg_rdata_out == 8'h00 || $past(reg_rd_in))
		else $error("control read data wrong or held");

	// ************************************************
	// Link, buffer and flag checks
	// ************************************************
	crc_slot_b_a: assert property (tick && r.cnt >= CRC_START && r.f[0][PRO_BIT_B]
		|=> cs_b_out == $past(crc_bit_b))
		else $error("B channel CRC bit not sent in last byte");
	msb_first_b_a: assert property (tick && r.cnt < CRC_START |=> cs_b_out == $past(tx_b))
		else $error("B channel bit out of order");
	plain_tail_a: assert property (tick && r.cnt >= CRC_START && !r.f[0][PRO_BIT_A]
		|=> cs_a_out == $past(tx_a))
		else $error("consumer block last byte replaced");
	start_pulse_a: assert property (block_start_out |-> r.cnt == 8'h01 ##1 !block_start_out)
		else $error("block start pulse misplaced");
	start_given_a: assert property (tick && r.cnt == 8'h00 |=> block_start_out)
		else $error("block start pulse missing");
	read_idle_a: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
		else $error("read data present without a read");
	hw_write_off_a: assert property (reg_wr_in && in_window && hw && !tick
		|=> r.e == $past(r.e))
		else $error("host write changed buffer in hardware mode");
	flag_set_a: assert property (tick && last && !inhibit |=> r.flag)
		else $error("handoff flag not set");
	flag_clear_a: assert property (reg_rd_in && reg_addr_in == STAT_ADDR
		&& !(tick && last && !inhibit) |=> !r.flag)
		else $error("handoff flag not cleared by status read");
	pair_first_a: assert property (reg_rd_in && in_window && two_byte && !tick
		|=> reg_rdata_out == r.e[$past(acc_idx)][15:8])
		else $error("first paired read was not the A byte");
	single_read_a: assert property (reg_rd_in && in_window && !two_byte && !tick
		|=> reg_rdata_out == ($past(r.ctrl[CTRL_RD_B]) ? r.e[$past(acc_idx)][7:0]
		: r.e[$past(acc_idx)][15:8]))
		else $error("single byte read from wrong half");
	pair_write_a: assert property (reg_wr_in && in_window && two_byte && !hw && !tick
		|=> r.e[$past(acc_idx)][15:8] == $past(reg_wdata_in) && r.half)
		else $error("paired write did not fill the A byte");
	stream_step_a: assert property (reg_wr_in && in_window && !two_byte && !hw
		|=> r.ptr == $past(next_idx))
		else $error("access pointer did not advance");
	serial_fill_a: assert property (tick && hw && r.pin2[PIN_SER_SEL]
		|=> r.e[$past(r.cnt[7:3])][8 + 7 - $past(r.cnt[2:0])] == $past(r.pin2[PIN_SER_DATA]))
		else $error("serial channel status bit not stored");
	irq_off_a: assert property (!r.ctrl[CTRL_IRQ_EN] |=> !handoff_irq_out)
		else $error("interrupt while disabled");
endmodule

/* File: verif/host_model.sv */
`timescale 1ns/1ps
// ****
// Host on the register port
// ****
module host_model (
	input  wire logic       clk_in,
	input  wire logic [7:0] rdata_in,
	output logic      [7:0] addr_out,
	output logic      [7:0] wdata_out,
	output logic            wr_out,
	output logic            rd_out
);
	initial begin
		addr_out = 8'h00;
		wdata_out = 8'h00;
		wr_out = 1'b0;
		rd_out = 1'b0;
	end
	// Idle cycle after each strobe so no strobe is driven twice in one step
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		addr_out <= a;
		wdata_out <= d;
		wr_out <= 1'b1;
		@(posedge clk_in);
		wr_out <= 1'b0;
		@(posedge clk_in);
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		addr_out <= a;
		rd_out <= 1'b1;
		@(posedge clk_in);
		rd_out <= 1'b0;
		@(posedge clk_in);
		d = rdata_in;
	endtask
	// Two reads with no gap: the second address continues the access
	task automatic rd2(input logic [7:0] a, input logic [7:0] b, output logic [7:0] d0,
		output logic [7:0] d1);
		addr_out <= a;
		rd_out <= 1'b1;
		@(posedge clk_in);
		addr_out <= b;
		@(posedge clk_in);
		rd_out <= 1'b0;
		d0 = rdata_in;
		@(posedge clk_in);
		d1 = rdata_in;
	endtask
endmodule

/* File: verif/cs_buffer_manager_tb_top.sv */
`timescale 1ns/1ps
module cs_buffer_manager_tb_top;
	import csb_pkg::*;
	logic         clk_in, arst_n_in, frame_clk, hw_mode, ser_sel, ser_bit, copy_pin, original_status_pin_pin;
	logic [7:0]   addr, wdata, rdata, d, d2;
	logic         wr, rd, cs_a, cs_b, blk, irq;
	logic [15:0]  img [WORDS];
	logic [191:0] cap_a, cap_b, ea, eb;
	int           num_errors, checks_done, irqs, v;
	int           seed = 32'h51061B58;

	initial begin
		clk_in = 1'b0;
		forever #4 clk_in = ~clk_in;
	end
	initial begin
		frame_clk = 1'b0;
		#3;
		forever #32 frame_clk = ~frame_clk;
	end
	always @(posedge clk_in) if (irq === 1'b1) irqs++;

	host_model h (.clk_in(clk_in), .rdata_in(rdata), .addr_out(addr), .wdata_out(wdata),
		.wr_out(wr), .rd_out(rd));
	cs_buffer_manager uut (.clk_in(clk_in), .arst_n_in(arst_n_in), .reg_addr_in(addr),
		.reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
		.frame_clk_in(frame_clk), .hw_mode_in(hw_mode), .hw_serial_sel_in(ser_sel),
		.cs_serial_in(ser_bit), .copy_permit_pin_in(copy_pin),
		.original_status_pin_in(original_status_pin_pin), .cs_a_out(cs_a), .cs_b_out(cs_b),
		.block_start_out(blk), .handoff_irq_out(irq));

	// ****
	// Helpers
	// ****
	task automatic check(input logic [191:0] got, input logic [191:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic final_report();
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic wait_for(input logic is_irq);
		int n;
		n = 0;
		while ((is_irq ? irq : blk) !== 1'b1) begin
			@(posedge clk_in);
			n++;
			if (n > 4000) begin
				num_errors++;
				final_report();
			end
		end
	endtask
	// Samples mid-frame, four clocks clear of each bit change
	task automatic capture(input int skip);
		for (int i = 0; i <= skip; i++) begin
			@(posedge clk_in);
			wait_for(1'b0);
		end
		repeat (3) @(posedge clk_in);
		for (int k = 191; k >= 0; k--) begin
			cap_a[k] = cs_a;
			cap_b[k] = cs_b;
			repeat (8) @(posedge clk_in);
		end
	endtask
	function automatic logic [191:0] exp_bits(input logic ch);
		logic [191:0] s;
		logic [7:0]   b;
		logic [7:0]   c;
		for (int k = 0; k < 192; k++) begin
			b = ch ? img[k / 8][7:0] : img[k / 8][15:8];
			s[191 - k] = b[7 - k % 8];
		end
		c = CRC_INIT;
		for (int k = 0; k < 184; k++) c = {c[6:0], 1'b0} ^ ((c[7] ^ s[191 - k]) ? CRC_POLY : 8'h00);
		if (s[191]) s[7:0] = c;
		return s;
	endfunction

	// ****
	// Main sequence
	// ****
	initial begin
		arst_n_in = 1'b0;
		hw_mode = 1'b0;
		ser_sel = 1'b0;
		ser_bit = 1'b0;
		copy_pin = 1'b0;
		original_status_pin_pin = 1'b0;
		num_errors = 0;
		checks_done = 0;
		irqs = 0;
		repeat (16) @(posedge clk_in);
		arst_n_in <= 1'b1;
		check({blk, irq, cs_a, cs_b}, 4'h0);
		h.rd(CTRL_ADDR, d);
		check(d, CTRL_RESET);
		h.rd(8'h05, d);
		check(d, 8'h00);
		$display("test reset done");
		for (int m = 0; m < 2; m++) begin
			h.wr(CTRL_ADDR, 8'(8 + m));
			wait_for(1'b1);
			for (int i = 0; i < WORDS; i++) begin
				v = $random(seed);
				img[i] = m ? v[15:0] : {2{v[7:0]}};
			end
			img[0] = m ? {1'b1, img[0][14:8], 1'b0, img[0][6:0]} : img[0] | 16'h8080;
			for (int i = 0; i < WORDS; i++) begin
				h.wr(i ? STREAM_ADDR : BUF_BASE, img[i][15:8]);
				if (m) h.wr(STREAM_ADDR, img[i][7:0]);
			end
			for (int p = 0; p < 2 - m; p++) begin
				h.wr(CTRL_ADDR, 8'(8 + m + 2 * p));
				for (int i = 0; i < WORDS; i++) begin
					if (m) begin
						h.rd2(i ? STREAM_ADDR : BUF_BASE, STREAM_ADDR, d, d2);
						check(d, img[i][15:8]);
						check(d2, img[i][7:0]);
					end else begin
						h.rd(i ? STREAM_ADDR : BUF_BASE, d);
						check(d, p ? img[i][7:0] : img[i][15:8]);
					end
				end
			end
			capture(0);
			check(cap_a, exp_bits(1'b0));
			check(cap_b, exp_bits(1'b1));
			$display("test mode %0d done", m);
		end
		ea = exp_bits(1'b0);
		eb = exp_bits(1'b1);
		h.wr(CTRL_ADDR, 8'h0C);
		h.rd(STAT_ADDR, d);
		irqs = 0;
		v = $random(seed);
		h.wr(BUF_BASE + 8'h05, v[7:0]);
		img[5] = {2{v[7:0]}};
		capture(1);
		check(cap_a, ea);
		check(cap_b, eb);
		check(irqs, 0);
		h.rd(STAT_ADDR, d);
		check(d[STAT_HANDOFF], 1'b0);
		h.wr(CTRL_ADDR, 8'h08);
		capture(1);
		check(cap_a, exp_bits(1'b0));
		check(cap_b, exp_bits(1'b1));
		h.rd(STAT_ADDR, d);
		check(d[STAT_HANDOFF], 1'b1);
		check(irqs > 0, 1'b1);
		$display("test inhibit done");
		v = $random(seed);
		hw_mode <= 1'b1;
		copy_pin <= v[0];
		original_status_pin_pin <= v[1];
		capture(1);
		check({cap_a[189], cap_a[176], cap_b[189], cap_b[176]}, {2{v[0], v[1]}});
		h.rd(STAT_ADDR, d);
		check(d[STAT_HW], 1'b1);
		$display("test pins done");
		ser_sel <= 1'b1;
		ser_bit <= 1'b1;
		for (int i = 0; i < WORDS; i++) img[i] = 16'hFFFF;
		capture(2);
		check(cap_a, exp_bits(1'b0));
		check(cap_b, exp_bits(1'b1));
		$display("test serial done");
		final_report();
	end
endmodule
